// ==== rtl/ser_params.svh ====
`ifndef SER_PARAMS_SVH
`define SER_PARAMS_SVH
// Register byte offsets (Avalon word aligned)
`define SER_OFF_CTRL 8'h00
`define SER_OFF_DEEM 8'h04
`define SER_OFF_ESE 8'h08
`define SER_OFF_SRE 8'h0C
`define SER_OFF_ESR 8'h10
`define SER_OFF_STB 8'h14
`define SER_OFF_POLL 8'h18
`define SER_OFF_EVENT 8'h1C
`define SER_OFF_EVMSG 8'h20
`define SER_OFF_RSPW 8'h24
`define SER_OFF_RSPR 8'h28
`define SER_OFF_EVIN 8'h2C
`define SER_OFF_QSTAT 8'h30
// Event status bit positions
`define SER_B_OPC 0
`define SER_B_QYE 2
`define SER_B_DDE 3
`define SER_B_EXE 4
`define SER_B_CME 5
`define SER_B_URQ 6
`define SER_B_PON 7
// Status byte bit positions
`define SER_SB_MAV 4
`define SER_SB_ESB 5
`define SER_SB_MSS 6
// Event codes
`define SER_C_EMPTY 10'd0
`define SER_C_PEND 10'd1
`define SER_C_CMD_LO 10'd100
`define SER_C_CMD_HI 10'd184
`define SER_C_EXE_LO 10'd200
`define SER_C_EXE_HI 10'd278
`define SER_C_CONFLICT 10'd221
`define SER_C_DEV_LO 10'd300
`define SER_C_DEV_HI 10'd315
`define SER_C_OVF 10'd350
`define SER_C_PON 10'd401
`define SER_C_OPC 10'd402
`define SER_C_URQ 10'd403
`define SER_C_QY_LO 10'd410
`define SER_C_QY_HI 10'd440
`define SER_C_WRN_LO 10'd500
`define SER_C_WRN_HI 10'd540
// Reset values
`define SER_RST_DEEM 8'hFF
`define SER_RST_ESE 8'h00
`define SER_RST_SRE 8'h00
// Detail text separator
`define SER_SEMI 8'h3B
`endif

// ==== rtl/ser_pkg.sv ====
package ser_pkg;
    typedef enum logic [1:0] {
        SER_IDLE = 2'b00,
        SER_RESP = 2'b01
    } ser_bus_t;
endpackage : ser_pkg

// ==== rtl/ser_rsp_if.sv ====
`timescale 1ns/100ps
`default_nettype none
// Response byte queue handshake between top and queue
interface ser_rsp_if;
    logic flush;
    logic push;
    logic [7:0] wdata;
    logic pop;
    logic [7:0] rdata;
    logic empty;
    logic full;
    logic lost;
    modport owner (output flush, push, wdata, pop, input rdata, empty, full, lost);
    modport queue (input flush, push, wdata, pop, output rdata, empty, full, lost);
endinterface : ser_rsp_if
`default_nettype wire

// ==== rtl/ser_rsp_queue.sv ====
`timescale 1ns/100ps
`default_nettype none
`include "ser_params.svh"
// Response byte queue, flip-flop storage
module ser_rsp_queue #(
    parameter int DEPTH = 1024
) (
    input wire logic clk_i,
    input wire logic rst_i,
    ser_rsp_if.queue q
);
    import ser_pkg::*;
    localparam int AW = $clog2(DEPTH);
    initial begin
        if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) $error("DEPTH must be a power of two");
    end
    typedef struct packed {
        logic [AW-1:0] rd;
        logic [AW-1:0] wr;
        logic [AW:0] cnt;
        logic lost;
    } ser_rq_t;
    ser_rq_t s_r, s_nxt;
    logic [7:0] mem_r [DEPTH];
    // Control state next value
    always_comb begin
        s_nxt = s_r;
        s_nxt.lost = 1'b0;
        if (q.flush) begin
            s_nxt.rd = '0;
            s_nxt.wr = '0;
            s_nxt.cnt = '0;
        end else begin
            if (q.push && s_r.cnt != (AW+1)'(DEPTH)) begin
                s_nxt.wr = s_r.wr + 1'b1;
            end else if (q.push) begin
                s_nxt.lost = 1'b1;
            end
            if (q.pop && s_r.cnt != '0) begin
                s_nxt.rd = s_r.rd + 1'b1;
            end
            s_nxt.cnt = s_r.cnt + (AW+1)'(q.push && s_r.cnt != (AW+1)'(DEPTH))
                - (AW+1)'(q.pop && s_r.cnt != '0);
        end
    end
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end
    // Storage has no reset; a read of an empty queue can return an unwritten slot
    always_ff @(posedge clk_i) begin
        if (!q.flush && q.push && s_r.cnt != (AW+1)'(DEPTH)) begin
            mem_r[s_r.wr] <= q.wdata;
        end
    end
    assign q.rdata = mem_r[s_r.rd];
    assign q.empty = (s_r.cnt == '0);
    assign q.full = (s_r.cnt == (AW+1)'(DEPTH));
    assign q.lost = s_r.lost;
endmodule : ser_rsp_queue
`default_nettype wire

// ==== rtl/ser_top.sv ====
// What this block does
// - Response queue holds at most 1024 bytes
// - New command or query flushes response queue, unless a control write with bit 0 clear lands in that cycle
// - Twenty events; overflow replaces last with 350
// - Code-only and code-plus-text reads, both remove
// - Status query releases events, clears status
// - Status query erases released unread events
// - Later events queue hidden until next query
// - Enable mask gates status bit and queue, except code 350
// - Enabled status bits set event summary
// - Response data sets message available
// - Enabled status byte bits raise service request
// - Setting conflict raises execution error bit 4
// - Conflict checked only at command end
// - Text carries a semicolon when detail is set; detail byte not returned
// - Empty reads 0, hidden pending reads 1
// - Codes 100-184 set command error bit 5
// - Codes 200-278 set execution error bit
// - Codes 300-315 set device error, 350 not
// - 401 power, 402 complete, 403 user request
// - Query faults 410-440 set query error bit 2
// - Warnings 500-540 set execution error bit
// - Status read returns and clears register
// - Request service holds until poll or summary drop
// - Empty read or lost data flags query error
`timescale 1ns/100ps
`default_nettype none
`include "ser_params.svh"
module ser_top #(
    parameter int EVQ_DEPTH = 20,
    parameter int RSP_DEPTH = 1024,
    parameter int TXT_LEN = 8
) (
    input wire logic REF_CLK_I,
    input wire logic RST_I,
    input wire logic [7:0] AVS_ADDRESS_I,
    input wire logic AVS_READ_I,
    input wire logic AVS_WRITE_I,
    input wire logic [31:0] AVS_WRITEDATA_I,
    output logic [31:0] AVS_READDATA_O,
    output logic AVS_WAITREQUEST_O,
    input wire logic MSG_START_I,
    input wire logic CMD_DONE_I,
    input wire logic CONFLICT_I,
    input wire logic USER_REQ_I,
    input wire logic OP_DONE_I,
    output logic SRQ_O,
    output logic [1:0] BUS_STATE_O
);
    import ser_pkg::*;
    localparam int EW = $clog2(EVQ_DEPTH + 1);
    initial begin
        if (EVQ_DEPTH < 2 || EVQ_DEPTH > 255) $error("EVQ_DEPTH out of range");
        if (TXT_LEN < 2 || TXT_LEN > 30) $error("TXT_LEN out of range");
    end

    typedef struct packed {
        logic [7:0] deem;
        logic [7:0] ese;
        logic [7:0] sre;
        logic [7:0] esr;
        logic rqs;
        logic mss_q;
        logic pon_pend;
        logic conflict_seen;
        logic [EW-1:0] cnt;
        logic [EW-1:0] avail;
        logic [31:0] rdata;
        logic ack;
        logic [7:0] detail;
        ser_bus_t bst;
    } ser_st_t;
    ser_st_t s_r, s_nxt;
    logic [9:0] evq_r [EVQ_DEPTH];
    logic [9:0] evq_nxt [EVQ_DEPTH];

    ser_rsp_if rsp ();
    ser_rsp_queue #(.DEPTH(RSP_DEPTH)) u_rsp (
        .clk_i(REF_CLK_I),
        .rst_i(RST_I),
        .q(rsp)
    );

    // Event status bit for a code; 0 means code sets nothing
    function automatic logic [7:0] ser_class(input logic [9:0] c);
        logic [7:0] b;
        b = 8'h00;
        if (c >= `SER_C_CMD_LO && c <= `SER_C_CMD_HI) b[`SER_B_CME] = 1'b1;
        else if (c >= `SER_C_EXE_LO && c <= `SER_C_EXE_HI) b[`SER_B_EXE] = 1'b1;
        else if (c >= `SER_C_DEV_LO && c <= `SER_C_DEV_HI) b[`SER_B_DDE] = 1'b1;
        else if (c == `SER_C_PON) b[`SER_B_PON] = 1'b1;
        else if (c == `SER_C_OPC) b[`SER_B_OPC] = 1'b1;
        else if (c == `SER_C_URQ) b[`SER_B_URQ] = 1'b1;
        else if (c >= `SER_C_QY_LO && c <= `SER_C_QY_HI) b[`SER_B_QYE] = 1'b1;
        else if (c >= `SER_C_WRN_LO && c <= `SER_C_WRN_HI) b[`SER_B_EXE] = 1'b1;
        return b;
    endfunction : ser_class

    // Short text per class; detail follows a semicolon
    function automatic logic [7:0] ser_txt(input logic [7:0] cls, input logic [7:0] det, input int i);
        logic [7:0] ch;
        ch = 8'h00;
        if (i == 0) ch = cls[`SER_B_CME] ? 8'h43 : cls[`SER_B_EXE] ? 8'h45 : cls[`SER_B_DDE] ? 8'h44 :
            cls[`SER_B_QYE] ? 8'h51 : 8'h53;
        else if (i == 1 && det != 8'h00) ch = `SER_SEMI;
        else if (i == 2) ch = det;
        return ch;
    endfunction : ser_txt

    logic is_rd, is_wr, rq_evt;
    logic [9:0] new_code, head;
    logic [7:0] head_cls, in_cls;
    logic [7:0] stb_w;
    int txt_idx;
    assign is_rd = AVS_READ_I && !s_r.ack;
    assign is_wr = AVS_WRITE_I && !s_r.ack;
    assign head = evq_r[0];
    assign head_cls = ser_class(head);

    always_comb begin
        s_nxt = s_r;
        s_nxt.ack = 1'b0;
        s_nxt.pon_pend = 1'b0;
        for (int i = 0; i < EVQ_DEPTH; i++) begin
            evq_nxt[i] = evq_r[i];
        end
        rsp.flush = 1'b0;
        rsp.push = 1'b0;
        rsp.pop = 1'b0;
        rsp.wdata = AVS_WRITEDATA_I[7:0];
        rq_evt = 1'b0;
        new_code = 10'd0;
        txt_idx = 0;
        // Conflicts only latched; checked at command end
        if (MSG_START_I) s_nxt.conflict_seen = 1'b0;
        if (CONFLICT_I) s_nxt.conflict_seen = 1'b1;
        if (MSG_START_I) rsp.flush = 1'b1;
        // Event sources, one per cycle, priority order
        if (s_r.pon_pend) begin
            rq_evt = 1'b1;
            new_code = `SER_C_PON;
        end else if (CMD_DONE_I && (s_r.conflict_seen || CONFLICT_I)) begin
            rq_evt = 1'b1;
            new_code = `SER_C_CONFLICT;
            s_nxt.conflict_seen = 1'b0;
        end else if (rsp.lost) begin
            rq_evt = 1'b1;
            new_code = `SER_C_QY_LO;
        end else if (OP_DONE_I) begin
            rq_evt = 1'b1;
            new_code = `SER_C_OPC;
        end else if (USER_REQ_I) begin
            rq_evt = 1'b1;
            new_code = `SER_C_URQ;
        end else if (is_wr && AVS_ADDRESS_I == `SER_OFF_EVIN) begin
            rq_evt = 1'b1;
            new_code = AVS_WRITEDATA_I[9:0];
        end
        // Bus access, answered in the cycle after it is seen
        s_nxt.rdata = 32'h0000_0000;
        if (is_rd || is_wr) s_nxt.ack = 1'b1;
        if (is_wr) begin
            if (AVS_ADDRESS_I == `SER_OFF_CTRL) begin
                rsp.flush = AVS_WRITEDATA_I[0];
            end else if (AVS_ADDRESS_I == `SER_OFF_DEEM) begin
                s_nxt.deem = AVS_WRITEDATA_I[7:0];
            end else if (AVS_ADDRESS_I == `SER_OFF_ESE) begin
                s_nxt.ese = AVS_WRITEDATA_I[7:0];
            end else if (AVS_ADDRESS_I == `SER_OFF_SRE) begin
                s_nxt.sre = AVS_WRITEDATA_I[7:0];
            end else if (AVS_ADDRESS_I == `SER_OFF_RSPW) begin
                s_nxt.detail = s_r.detail;
                rsp.push = !MSG_START_I;
            end else if (AVS_ADDRESS_I == `SER_OFF_POLL) begin
                s_nxt.detail = AVS_WRITEDATA_I[7:0];
            end
        end
        if (is_rd) begin
            if (AVS_ADDRESS_I == `SER_OFF_DEEM) begin
                s_nxt.rdata[7:0] = s_r.deem;
            end else if (AVS_ADDRESS_I == `SER_OFF_ESE) begin
                s_nxt.rdata[7:0] = s_r.ese;
            end else if (AVS_ADDRESS_I == `SER_OFF_SRE) begin
                s_nxt.rdata[7:0] = s_r.sre;
            end else if (AVS_ADDRESS_I == `SER_OFF_ESR) begin
                s_nxt.rdata[7:0] = s_r.esr;
                s_nxt.esr = 8'h00;
                // Drop unread released events, release the rest
                for (int i = 0; i < EVQ_DEPTH; i++) begin
                    if (i + int'(s_r.avail) < EVQ_DEPTH) evq_nxt[i] = evq_r[i + int'(s_r.avail)];
                end
                s_nxt.cnt = s_r.cnt - s_r.avail;
                s_nxt.avail = s_r.cnt - s_r.avail;
            end else if (AVS_ADDRESS_I == `SER_OFF_STB) begin
                s_nxt.rdata[7:0] = {1'b0, s_r.mss_q, 6'h00} | stb_w;
            end else if (AVS_ADDRESS_I == `SER_OFF_POLL) begin
                s_nxt.rdata[7:0] = {1'b0, s_r.rqs, 6'h00} | stb_w;
                s_nxt.rqs = 1'b0;
            end else if (AVS_ADDRESS_I == `SER_OFF_EVENT || AVS_ADDRESS_I == `SER_OFF_EVMSG) begin
                if (s_r.avail != '0) begin
                    s_nxt.rdata[9:0] = head;
                    if (AVS_ADDRESS_I == `SER_OFF_EVMSG) begin
                        // Only class letter and separator fit in the word
                        for (int k = 0; k < 2; k++) begin
                            txt_idx = k;
                            s_nxt.rdata[16 + 8*k +: 8] = ser_txt(head_cls, s_r.detail, txt_idx);
                        end
                    end
                    for (int i = 0; i < EVQ_DEPTH - 1; i++) begin
                        evq_nxt[i] = evq_r[i + 1];
                    end
                    s_nxt.cnt = s_r.cnt - 1'b1;
                    s_nxt.avail = s_r.avail - 1'b1;
                end else if (s_r.cnt != '0) begin
                    s_nxt.rdata[9:0] = `SER_C_PEND;
                end else begin
                    s_nxt.rdata[9:0] = `SER_C_EMPTY;
                end
            end else if (AVS_ADDRESS_I == `SER_OFF_RSPR) begin
                s_nxt.rdata[7:0] = rsp.rdata;
                rsp.pop = 1'b1;
                if (rsp.empty) begin
                    rq_evt = 1'b1;
                    new_code = `SER_C_QY_HI;
                end
            end else if (AVS_ADDRESS_I == `SER_OFF_QSTAT) begin
                s_nxt.rdata[15:0] = {3'b000, rsp.full, rsp.empty, 3'b000, 8'(s_r.cnt)};
            end
        end
        // Enabled event: set status bit and enqueue, set beats clear
        in_cls = ser_class(new_code);
        if (rq_evt && ((in_cls & s_r.deem) != 8'h00 || new_code == `SER_C_OVF)) begin
            s_nxt.esr = s_nxt.esr | (in_cls & s_r.deem);
            if (s_nxt.cnt < EW'(EVQ_DEPTH)) begin
                evq_nxt[s_nxt.cnt] = new_code;
                s_nxt.cnt = s_nxt.cnt + 1'b1;
            end else begin
                evq_nxt[EVQ_DEPTH - 1] = `SER_C_OVF;
                if (s_nxt.avail == EW'(EVQ_DEPTH)) s_nxt.avail = s_nxt.avail - 1'b1;
            end
        end
        // Service request follows the enabled summary
        s_nxt.mss_q = |(stb_w & s_r.sre);
        if (s_nxt.mss_q && !s_r.mss_q) s_nxt.rqs = 1'b1;
        if (!s_nxt.mss_q) s_nxt.rqs = 1'b0;
        s_nxt.bst = rsp.empty ? SER_IDLE : SER_RESP;
    end

    // Status byte event summary and message available
    always_comb begin
        stb_w = 8'h00;
        stb_w[`SER_SB_ESB] = |(s_r.esr & s_r.ese);
        stb_w[`SER_SB_MAV] = !rsp.empty;
    end

    // Registered state; power-on event reported once after reset
    always_ff @(posedge REF_CLK_I) begin
        if (RST_I) begin
            s_r <= '0;
            s_r.deem <= `SER_RST_DEEM;
            s_r.ese <= `SER_RST_ESE;
            s_r.sre <= `SER_RST_SRE;
            s_r.pon_pend <= 1'b1;
            s_r.bst <= SER_IDLE;
        end else begin
            s_r <= s_nxt;
        end
    end
    // Event entries, shifted on removal
    always_ff @(posedge REF_CLK_I) begin
        for (int i = 0; i < EVQ_DEPTH; i++) begin
            if (RST_I) evq_r[i] <= 10'd0;
            else evq_r[i] <= evq_nxt[i];
        end
    end

    // One wait state on every access
    assign AVS_WAITREQUEST_O = (AVS_READ_I || AVS_WRITE_I) && !s_r.ack;
    assign AVS_READDATA_O = s_r.rdata;
    assign SRQ_O = s_r.rqs;
    assign BUS_STATE_O = s_r.bst;
endmodule : ser_top
`default_nettype wire

// ==== sim/ser_host.sv ====
`timescale 1ns/100ps
`default_nettype none
// Avalon master standing in for the bus controller
module ser_host (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic go_i,
    input wire logic we_i,
    input wire logic [7:0] addr_i,
    input wire logic [31:0] wdata_i,
    input wire logic wait_i,
    input wire logic [31:0] rdata_i,
    output logic rd_o,
    output logic wr_o,
    output logic [7:0] addr_o,
    output logic [31:0] wdata_o,
    output logic [31:0] q_o,
    output logic done_o
);
    // Request held until waitrequest is sampled low, then released
    always_ff @(posedge clk_i) begin
        done_o <= 1'b0;
        if (rst_i) begin
            rd_o <= 1'b0;
            wr_o <= 1'b0;
        end else if ((rd_o || wr_o) && !wait_i) begin
            q_o <= rdata_i;
            rd_o <= 1'b0;
            wr_o <= 1'b0;
            wdata_o <= ~wdata_o; // Released data must not look valid
            done_o <= 1'b1;
        end else if (!rd_o && !wr_o && go_i) begin
            rd_o <= !we_i;
            wr_o <= we_i;
            addr_o <= addr_i;
            wdata_o <= wdata_i;
        end
    end
endmodule : ser_host
`default_nettype wire

// ==== sim/ser_top_sva.sv ====
`timescale 1ns/100ps
`default_nettype none
`include "ser_params.svh"
module ser_top_sva
    import ser_pkg::*;
(
    input wire logic REF_CLK_I,
    input wire logic RST_I,
    input wire logic [7:0] AVS_ADDRESS_I,
    input wire logic AVS_READ_I,
    input wire logic AVS_WRITE_I,
    input wire logic [31:0] AVS_WRITEDATA_I,
    input wire logic [31:0] AVS_READDATA_O,
    input wire logic AVS_WAITREQUEST_O,
    input wire logic MSG_START_I,
    input wire logic CMD_DONE_I,
    input wire logic CONFLICT_I,
    input wire logic USER_REQ_I,
    input wire logic OP_DONE_I,
    input wire logic SRQ_O,
    input wire logic [1:0] BUS_STATE_O
);
    logic quiet_r;
    wire logic act = AVS_READ_I || AVS_WRITE_I || MSG_START_I;
    wire logic evt = CMD_DONE_I || CONFLICT_I || USER_REQ_I || OP_DONE_I || AVS_WRITE_I
        || (AVS_READ_I && AVS_ADDRESS_I == `SER_OFF_RSPR);
    default clocking @(posedge REF_CLK_I); endclocking
    default disable iff (RST_I);
    // Accesses completing at the edge where waitrequest is low
    sequence s_rd(logic [7:0] a);
        AVS_READ_I && !AVS_WAITREQUEST_O && AVS_ADDRESS_I == a;
    endsequence
    sequence s_wr(logic [7:0] a);
        AVS_WRITE_I && !AVS_WAITREQUEST_O && AVS_ADDRESS_I == a;
    endsequence
    // Set by a status read; cleared by anything that might raise an event
    always_ff @(posedge REF_CLK_I) begin
        if (RST_I || evt) quiet_r <= 1'b0;
        else if (AVS_READ_I && !AVS_WAITREQUEST_O && AVS_ADDRESS_I == `SER_OFF_ESR) quiet_r <= 1'b1;
    end
    a_wait_first: assert property ($rose(AVS_READ_I) |-> AVS_WAITREQUEST_O)
        else $error("read taken without wait");
    a_wait_once: assert property (AVS_WAITREQUEST_O && (AVS_READ_I || AVS_WRITE_I) |=> !AVS_WAITREQUEST_O)
        else $error("access waited too long");
    a_flush_empty: assert property (MSG_START_I |-> ##[1:2] BUS_STATE_O == SER_IDLE)
        else $error("queue not flushed on new message");
    a_ctrl_flush: assert property (s_wr(`SER_OFF_CTRL) ##0 AVS_WRITEDATA_I[0] |-> ##[1:2] BUS_STATE_O == SER_IDLE)
        else $error("queue not flushed by control");
    a_push_mav: assert property (s_wr(`SER_OFF_RSPW) ##0 !MSG_START_I |-> ##[1:2] BUS_STATE_O == SER_RESP)
        else $error("pushed byte not available");
    a_poll_clear: assert property (s_rd(`SER_OFF_POLL) |-> ##[1:2] !SRQ_O)
        else $error("poll left service request");
    a_srq_drop: assert property ($fell(SRQ_O) |-> $past(act) || $past(act, 2))
        else $error("service request dropped alone");
    a_esr_clear: assert property (s_rd(`SER_OFF_ESR) ##0 quiet_r |-> AVS_READDATA_O[7:0] == 8'h00)
        else $error("status not cleared by read");
endmodule : ser_top_sva
bind ser_top ser_top_sva u_sva (.REF_CLK_I(REF_CLK_I), .RST_I(RST_I), .AVS_ADDRESS_I(AVS_ADDRESS_I),
    .AVS_READ_I(AVS_READ_I), .AVS_WRITE_I(AVS_WRITE_I), .AVS_WRITEDATA_I(AVS_WRITEDATA_I),
    .AVS_READDATA_O(AVS_READDATA_O), .AVS_WAITREQUEST_O(AVS_WAITREQUEST_O), .MSG_START_I(MSG_START_I),
    .CMD_DONE_I(CMD_DONE_I), .CONFLICT_I(CONFLICT_I), .USER_REQ_I(USER_REQ_I), .OP_DONE_I(OP_DONE_I),
    .SRQ_O(SRQ_O), .BUS_STATE_O(BUS_STATE_O));
`default_nettype wire

// ==== sim/ser_top_test.sv ====
`timescale 1ns/100ps
`default_nettype none
`include "ser_params.svh"
module ser_top_test;
    import ser_pkg::*;
    localparam logic [7:0] ES = `SER_OFF_ESR, EV = `SER_OFF_EVENT, IN = `SER_OFF_EVIN, RW = `SER_OFF_RSPW;
    localparam logic [7:0] RR = `SER_OFF_RSPR, QS = `SER_OFF_QSTAT, SB = `SER_OFF_STB;
    localparam logic [31:0] LO = 32'h3FF, BY = 32'hFF;
    logic clk = 1'b0, rst = 1'b1, go = 1'b0, we = 1'b0, done, rd, wr, wt, srq;
    logic [7:0] ad = 8'h00, avad;
    logic [31:0] wd = 32'h0, avwd, q, rdat;
    logic [4:0] ev = 5'h00;
    logic [1:0] bst;
    int failures = 0, n_checks = 0, cyc = 0;
    ser_top #(.RSP_DEPTH(16)) dut (.REF_CLK_I(clk), .RST_I(rst), .AVS_ADDRESS_I(avad), .AVS_READ_I(rd),
        .AVS_WRITE_I(wr), .AVS_WRITEDATA_I(avwd), .AVS_READDATA_O(rdat), .AVS_WAITREQUEST_O(wt),
        .MSG_START_I(ev[0]), .CMD_DONE_I(ev[1]), .CONFLICT_I(ev[2]), .USER_REQ_I(ev[3]), .OP_DONE_I(ev[4]),
        .SRQ_O(srq), .BUS_STATE_O(bst));
    ser_host host (.clk_i(clk), .rst_i(rst), .go_i(go), .we_i(we), .addr_i(ad), .wdata_i(wd), .wait_i(wt),
        .rdata_i(rdat), .rd_o(rd), .wr_o(wr), .addr_o(avad), .wdata_o(avwd), .q_o(q), .done_o(done));
    // 10 MHz clock
    initial forever #50 clk = ~clk;
    task automatic wrap_up();
        if (failures == 0 && n_checks > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask : wrap_up
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            failures++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    // One bus access through the host; waits for its completion, bounded
    task automatic acc(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        we <= w;
        ad <= a;
        wd <= d;
        go <= 1'b1;
        @(posedge clk);
        go <= 1'b0;
        @(posedge clk);
        while (done !== 1'b1 && n < 20) begin
            @(posedge clk);
            n++;
        end
        if (n >= 20) failures++;
    endtask : acc
    task automatic rdc(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
        acc(1'b0, a, 32'h0);
        chk(q & m, e);
    endtask : rdc
    task automatic pulse(input logic [4:0] m);
        ev <= m;
        @(posedge clk);
        ev <= 5'h00;
        @(posedge clk);
    endtask : pulse
    task automatic t_reset();
        rdc(`SER_OFF_DEEM, BY, `SER_RST_DEEM);
        rdc(`SER_OFF_SRE, BY, `SER_RST_SRE);
        acc(1'b1, 8'hFC, 32'h5A);
        rdc(8'hFC, 32'hFFFFFFFF, 32'h0);
        rdc(EV, LO, `SER_C_PEND);
        rdc(ES, BY, 32'h80);
        rdc(EV, LO, `SER_C_PON);
        rdc(EV, LO, `SER_C_EMPTY);
        rdc(ES, BY, 32'h0);
    endtask : t_reset
    task automatic t_hidden();
        acc(1'b1, `SER_OFF_ESE, 32'h01);
        acc(1'b1, `SER_OFF_SRE, 32'h20);
        pulse(5'h10);
        rdc(SB, 32'h60, 32'h60);
        chk(srq, 1'b1);
        rdc(EV, LO, `SER_C_PEND);
        rdc(ES, BY, 32'h01);
        rdc(SB, 32'h60, 32'h0);
        chk(srq, 1'b0);
        rdc(EV, LO, `SER_C_OPC);
        acc(1'b1, `SER_OFF_ESE, 32'h0);
        acc(1'b1, `SER_OFF_SRE, 32'h0);
    endtask : t_hidden
    task automatic t_erase();
        pulse(5'h08);
        pulse(5'h10);
        rdc(ES, BY, 32'h41);
        rdc(EV, LO, `SER_C_URQ);
        rdc(ES, BY, 32'h0);
        rdc(EV, LO, `SER_C_EMPTY);
        acc(1'b1, `SER_OFF_DEEM, 32'hFE);
        pulse(5'h10);
        rdc(ES, BY, 32'h0);
        rdc(EV, LO, `SER_C_EMPTY);
        acc(1'b1, `SER_OFF_DEEM, 32'hFF);
    endtask : t_erase
    task automatic t_classes();
        logic [9:0] cs [12] = '{`SER_C_CMD_LO, `SER_C_CMD_HI, `SER_C_EXE_LO, `SER_C_CONFLICT, `SER_C_EXE_HI,
            `SER_C_DEV_LO, `SER_C_DEV_HI, `SER_C_QY_LO, 10'h1A4, `SER_C_QY_HI, `SER_C_WRN_LO, `SER_C_WRN_HI};
        logic [7:0] bs [12] = '{8'h20, 8'h20, 8'h10, 8'h10, 8'h10, 8'h08, 8'h08, 8'h04, 8'h04, 8'h04, 8'h10, 8'h10};
        for (int i = 0; i < 12; i++) begin
            acc(1'b1, IN, 32'(cs[i]));
            rdc(ES, BY, 32'(bs[i]));
            rdc(EV, LO, 32'(cs[i]));
        end
        acc(1'b1, IN, `SER_C_OVF);
        rdc(ES, BY, 32'h0);
        rdc(EV, LO, `SER_C_OVF);
        acc(1'b1, `SER_OFF_POLL, 32'h05);
        acc(1'b1, IN, `SER_C_EXE_LO);
        rdc(ES, BY, 32'h10);
        rdc(`SER_OFF_EVMSG, 32'hFF0003FF, 32'h3B0000C8);
    endtask : t_classes
    task automatic t_conflict();
        pulse(5'h04);
        rdc(ES, BY, 32'h0);
        pulse(5'h06);
        rdc(ES, BY, 32'h10);
        rdc(EV, LO, `SER_C_CONFLICT);
    endtask : t_conflict
    task automatic t_overflow();
        for (int i = 0; i < 21; i++) acc(1'b1, IN, `SER_C_WRN_LO);
        rdc(ES, BY, 32'h10);
        rdc(QS, BY, 32'h14);
        for (int i = 0; i < 19; i++) rdc(EV, LO, `SER_C_WRN_LO);
        rdc(EV, LO, `SER_C_OVF);
        rdc(EV, LO, `SER_C_EMPTY);
    endtask : t_overflow
    task automatic t_resp();
        acc(1'b1, `SER_OFF_SRE, 32'h10);
        for (int i = 0; i < 3; i++) acc(1'b1, RW, 32'hA0 + i);
        chk(bst, SER_RESP);
        rdc(SB, 32'h50, 32'h50);
        rdc(`SER_OFF_POLL, 32'h40, 32'h40);
        chk(srq, 1'b0);
        rdc(RR, BY, 32'hA0);
        rdc(RR, BY, 32'hA1);
        // New message arrives: the unread byte is discarded
        pulse(5'h01);
        // Queue state reaches the pin one edge after the flush
        @(posedge clk);
        chk(bst, SER_IDLE);
        acc(1'b0, RR, 32'h0);
        rdc(ES, BY, 32'h04);
        rdc(EV, LO, `SER_C_QY_HI);
        for (int i = 0; i < 17; i++) acc(1'b1, RW, 32'(i));
        rdc(QS, 32'h1000, 32'h1000);
        rdc(ES, BY, 32'h04);
        rdc(EV, LO, `SER_C_QY_LO);
        acc(1'b1, `SER_OFF_CTRL, 32'h01);
        chk(bst, SER_IDLE);
    endtask : t_resp
    // Main sequence; some event fetches come before the status read, to see the pending code
    initial begin
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        t_reset();
        t_hidden();
        t_erase();
        t_classes();
        t_conflict();
        t_overflow();
        t_resp();
        wrap_up();
    end
    // Hang guard, well above the expected run length
    always @(posedge clk) begin
        cyc++;
        if (cyc == 5000) begin
            failures++;
            wrap_up();
        end
    end
endmodule : ser_top_test
`default_nettype wire
